// File: logic/iai_pkg.sv
package iai_pkg;
    // bus geometry: printed offsets are word indices, byte address is index * 4
    localparam int WB_ADR_W   = 10;
    localparam int WB_DAT_W   = 32;
    localparam int BYTE_SHIFT = 2;
    localparam int REG_W      = 8;
    localparam int IDX_W      = 8;

    // register indices
    localparam logic [IDX_W-1:0] IDX_STAT2   = 8'h13;  // line event pending flags
    localparam logic [IDX_W-1:0] IDX_STAT3   = 8'h14;  // indirect done pending flag
    localparam logic [IDX_W-1:0] IDX_EN2     = 8'h16;  // irq_enable_alarm_line
    localparam logic [IDX_W-1:0] IDX_EN3     = 8'h17;  // irq_enable_indirect
    localparam logic [IDX_W-1:0] IDX_DATA_LO = 8'h1C;  // indirect_data_low
    localparam logic [IDX_W-1:0] IDX_DATA_HI = 8'h1D;  // indirect_data_high
    localparam logic [IDX_W-1:0] IDX_ADDR    = 8'h1E;  // indirect_address
    localparam logic [IDX_W-1:0] IDX_ISTAT   = 8'h1F;  // indirect busy status

    // field positions
    localparam int ALARM_N   = 6;
    localparam int ALARM_LSB = 2;
    localparam int LOOP_BIT  = 1;
    localparam int TRIP_BIT  = 0;
    localparam int DONE_BIT  = 1;
    localparam int SPARE_BIT = 0;
    localparam int BUSY_BIT  = 0;

    // reset values and write masks
    localparam logic [REG_W-1:0] EN2_RST   = 8'h00;
    localparam logic [REG_W-1:0] EN3_RST   = 8'h00;
    localparam logic [REG_W-1:0] EN3_WMASK = 8'h03;
    localparam logic [REG_W-1:0] STAT_RST  = 8'h00;
    localparam logic [15:0]      DATA_RST  = 16'h0000;
    localparam logic [IDX_W-1:0] ADDR_RST  = 8'h00;

    // indirect store
    localparam int IND_DATA_W = 16;
    localparam int IND_DEPTH  = 256;

    // update tick timing
    localparam int CLK_HZ      = 20_000_000;
    localparam int UPDATE_HZ   = 16_000;
    localparam int TICK_CYCLES = CLK_HZ / UPDATE_HZ;
    localparam int TICK_W      = 11;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TICK_W-1:0] TICK_ZERO = 11'h000;

    // indirect request sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TICK, ST_LOAD} iai_state_type;
endpackage

// File: logic/iai_indirect_store.sv
`timescale 1ns/1ns
// indirect register file, one write port and one registered read port
module iai_indirect_store (
    input  wire logic                            ref_clk,
    input  wire logic                            wr_en,
    input  wire logic [iai_pkg::IDX_W-1:0]       loc,
    input  wire logic [iai_pkg::IND_DATA_W-1:0]  wr_data,
    output logic      [iai_pkg::IND_DATA_W-1:0]  rd_data
);
    import iai_pkg::*;

    // storage has no reset: contents are undefined until software writes them
    logic [IND_DATA_W-1:0] mem [IND_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // write on request, read every cycle so the result lags the address by one
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[loc] <= wr_data;
        end
        rd_data <= mem[loc];
    end
endmodule // iai_indirect_store

// File: logic/iai_regs.sv
`timescale 1ns/1ns
module iai_regs (
    input  wire logic                           ref_clk,
    input  wire logic                           rstn,
    input  wire logic [iai_pkg::WB_ADR_W-1:0]   wb_adr_i,
    input  wire logic [iai_pkg::WB_DAT_W-1:0]   wb_dat_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic                           wb_we_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    output logic      [iai_pkg::WB_DAT_W-1:0]   wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic [iai_pkg::ALARM_N-1:0]    alarm_evt,
    input  wire logic                           loop_closure_evt,
    input  wire logic                           ring_trip_evt,
    output logic                                irq_o
);
    import iai_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [REG_W-1:0]      en_alarm_line;   // irq_enable_alarm_line
    logic [REG_W-1:0]      en_indirect;     // irq_enable_indirect, masked storage
    logic [REG_W-1:0]      line_pending;    // alarm, loop closure, ring trip flags
    logic                  indirect_done_pending;
    logic [IND_DATA_W-1:0] indirect_data_word;
    logic [IDX_W-1:0]      indirect_location;
    logic                  indirect_busy_status;
    logic                  op_write;        // request kind latched at address write
    logic                  data_dirty;      // data touched since last address write
    iai_state_type         state;
    logic [TICK_W-1:0]     tick_cnt;
    logic                  tick;            // one cycle pulse at the update rate
    logic [IND_DATA_W-1:0] store_rd_data;

    // write strobe helper, used for every writable register
    function automatic logic wr_hit(input logic fire, input logic [IDX_W-1:0] cur,
                                    input logic [IDX_W-1:0] idx);
        return fire && (cur == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire [IDX_W-1:0] reg_idx = wb_adr_i[WB_ADR_W-1:BYTE_SHIFT];
    wire             bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land on the edge where the master sees ack, lane 0 only
    wire             wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [REG_W-1:0] wr_byte = wb_dat_i[REG_W-1:0];

    wire wr_stat2 = wr_hit(wr_fire, reg_idx, IDX_STAT2);
    wire wr_stat3 = wr_hit(wr_fire, reg_idx, IDX_STAT3);
    wire wr_en2   = wr_hit(wr_fire, reg_idx, IDX_EN2);
    wire wr_en3   = wr_hit(wr_fire, reg_idx, IDX_EN3);
    wire wr_dlo   = wr_hit(wr_fire, reg_idx, IDX_DATA_LO);
    wire wr_dhi   = wr_hit(wr_fire, reg_idx, IDX_DATA_HI);
    wire wr_addr  = wr_hit(wr_fire, reg_idx, IDX_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // pending flags: an event in the clearing cycle survives the clear
    wire [REG_W-1:0] line_evt = {alarm_evt, loop_closure_evt, ring_trip_evt};
    wire [REG_W-1:0] line_clr = wr_stat2 ? wr_byte : STAT_RST;
    wire [REG_W-1:0] next_line_pending = (line_pending & ~line_clr) | line_evt;

    // sequencer completion: write finishes at the tick, read one cycle later
    wire finish_wr = (state == ST_WAIT_TICK) && tick && op_write;
    wire finish_rd = (state == ST_LOAD);
    wire done_set  = finish_wr | finish_rd;
    wire done_clr  = wr_stat3 & wr_byte[DONE_BIT];
    wire next_done = (indirect_done_pending & ~done_clr) | done_set;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: each flag gated by its own enable
    wire [REG_W-1:0] line_gated = line_pending & en_alarm_line;
    wire             done_gated = indirect_done_pending & en_indirect[DONE_BIT];
    wire             next_irq   = (|line_gated) | done_gated;

    ////////////////////////////////////////////////////////////////////////////
    // read data selection, reserved bits return zero
    wire [REG_W-1:0] stat3_byte = REG_W'(indirect_done_pending) << DONE_BIT;
    wire [REG_W-1:0] istat_byte = REG_W'(indirect_busy_status) << BUSY_BIT;
    wire [REG_W-1:0] rd_byte =
        (reg_idx == IDX_STAT2)   ? line_pending :
        (reg_idx == IDX_STAT3)   ? stat3_byte :
        (reg_idx == IDX_EN2)     ? en_alarm_line :
        (reg_idx == IDX_EN3)     ? (en_indirect & EN3_WMASK) :
        (reg_idx == IDX_DATA_LO) ? indirect_data_word[REG_W-1:0] :
        (reg_idx == IDX_DATA_HI) ? indirect_data_word[IND_DATA_W-1:REG_W] :
        (reg_idx == IDX_ADDR)    ? indirect_location :
        (reg_idx == IDX_ISTAT)   ? istat_byte :
                                   STAT_RST;  // unmapped reads zero, still acked
    wire [WB_DAT_W-1:0] next_dat = WB_DAT_W'(rd_byte);

    ////////////////////////////////////////////////////////////////////////////
    // bus answer: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_dat : wb_dat_o;
        end
    end

    // enables, reserved bits 7:2 of enable three never stored
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            en_alarm_line <= EN2_RST;
            en_indirect   <= EN3_RST;
        end else begin
            if (wr_en2) begin
                en_alarm_line <= wr_byte;
            end
            if (wr_en3) begin
                en_indirect <= wr_byte & EN3_WMASK;
            end
        end
    end

    // sticky flags and interrupt output
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            line_pending          <= STAT_RST;
            indirect_done_pending <= 1'b0;
            irq_o                 <= 1'b0;
        end else begin
            line_pending          <= next_line_pending;
            indirect_done_pending <= next_done;
            irq_o                 <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // update tick divider, free running
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= TICK_ZERO;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= (tick_cnt == TICK_LAST) ? TICK_ZERO : tick_cnt + 1'b1;
            tick     <= (tick_cnt == TICK_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indirect request sequencer
    // a new address write restarts the request; the software is expected to
    // wait for busy to clear first, so no queueing is provided
    wire iaddr_go = (state == ST_WAIT_TICK) && tick && !op_write;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state                <= ST_IDLE;
            indirect_busy_status <= 1'b0;
            op_write             <= 1'b0;
        end else if (wr_addr) begin
            // kind fixed now: write if data was loaded first
            state                <= ST_WAIT_TICK;
            indirect_busy_status <= 1'b1;
            op_write             <= data_dirty;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    state <= ST_IDLE;
                end
                ST_WAIT_TICK: begin
                    if (finish_wr) begin
                        state                <= ST_IDLE;
                        indirect_busy_status <= 1'b0;
                    end else if (iaddr_go) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state                <= ST_IDLE;
                    indirect_busy_status <= 1'b0;
                end
            endcase
        end
    end

    // data window and address register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            indirect_data_word <= DATA_RST;
            indirect_location  <= ADDR_RST;
            data_dirty         <= 1'b0;
        end else begin
            if (finish_rd) begin
                // read result wins over a stray data write
                indirect_data_word <= store_rd_data;
            end else begin
                if (wr_dlo) begin
                    indirect_data_word[REG_W-1:0] <= wr_byte;
                end
                if (wr_dhi) begin
                    indirect_data_word[IND_DATA_W-1:REG_W] <= wr_byte;
                end
            end
            if (wr_addr) begin
                indirect_location <= wr_byte;
                data_dirty        <= 1'b0;
            end else if (wr_dlo | wr_dhi) begin
                data_dirty <= 1'b1;
            end
        end
    end

    // indirect register file
    iai_indirect_store u_store (
        .ref_clk (ref_clk),
        .wr_en   (finish_wr),
        .loc     (indirect_location),
        .wr_data (indirect_data_word),
        .rd_data (store_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // helper: age of the outstanding request, bounded by one tick period
    logic [TICK_W:0] busy_age;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_age <= '0;
        end else begin
            busy_age <= (indirect_busy_status && !wr_addr) ? busy_age + 1'b1 : '0;
        end
    end

    a_irq_level: assert property (irq_o == $past(next_irq))
        else $error("irq output does not follow gated flags");
    a_alarm_gate: assert property (
        (|(line_pending[REG_W-1:ALARM_LSB] & en_alarm_line[REG_W-1:ALARM_LSB])) |=> irq_o)
        else $error("enabled power alarm did not raise irq");
    a_loop_gate: assert property (
        (line_pending[LOOP_BIT] && en_alarm_line[LOOP_BIT]) |=> irq_o)
        else $error("enabled loop closure did not raise irq");
    a_trip_gate: assert property (
        (line_pending[TRIP_BIT] && en_alarm_line[TRIP_BIT]) |=> irq_o)
        else $error("enabled ring trip did not raise irq");
    a_done_gate: assert property (
        (!indirect_done_pending || !en_indirect[DONE_BIT]) && !(|line_gated) |=> !irq_o)
        else $error("irq raised with nothing enabled");
    a_en3_reserved: assert property (
        (bus_req && !wb_we_i && reg_idx == IDX_EN3) |=> (wb_dat_o[REG_W-1:ALARM_LSB] == '0))
        else $error("reserved enable bits read nonzero");
    a_data_write: assert property (
        (wr_dlo && !finish_rd) |=> indirect_data_word[REG_W-1:0] == $past(wr_byte))
        else $error("low data byte not stored");
    a_addr_write: assert property (
        wr_addr |=> (indirect_location == $past(wr_byte)) && indirect_busy_status)
        else $error("address write not stored or not pending");
    a_read_load: assert property (
        finish_rd |=> indirect_data_word == $past(store_rd_data))
        else $error("indirect read result not loaded");
    a_busy_bound: assert property (busy_age <= (TICK_W+1)'(TICK_CYCLES + 1))
        else $error("indirect request outstanding beyond one tick");
    a_done_flag: assert property ($fell(indirect_busy_status) |-> indirect_done_pending)
        else $error("completed request left done flag clear");
    a_clear_one: assert property (
        (wr_stat2 && wr_byte[TRIP_BIT] && !ring_trip_evt) |=> !line_pending[TRIP_BIT])
        else $error("write one did not clear flag");

    // sequencer and window checks; the tick gate matters because a write
    // committed early would race the second data byte
    a_write_tick: assert property (
        (state == ST_WAIT_TICK && op_write && !tick && !wr_addr) |=> state == ST_WAIT_TICK)
        else $error("indirect write left wait before the tick");
    a_idle_free: assert property ((state == ST_IDLE) |-> !indirect_busy_status)
        else $error("busy status set with no request outstanding");
    a_done_wins: assert property (
        (done_set && done_clr) |=> indirect_done_pending)
        else $error("clear beat a completion in the same cycle");
    a_en3_store: assert property (
        wr_en3 |=> (en_indirect[REG_W-1:ALARM_LSB] == '0))
        else $error("reserved enable bits were stored");
    a_data_high: assert property (
        (wr_dhi && !finish_rd) |=> indirect_data_word[IND_DATA_W-1:REG_W] == $past(wr_byte))
        else $error("high data byte not stored");

    c_sel_skip: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !wb_sel_i[0]);
    c_write_op: cover property (finish_wr);
    c_read_op:  cover property (finish_rd);
    c_irq_rise: cover property ($rose(irq_o));
    c_restart:  cover property (wr_addr && indirect_busy_status);
endmodule // iai_regs

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import iai_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    // bench signals, bus and event inputs driven by non-blocking assignment at the rising edge
    logic        ref_clk;    // 20 MHz bench clock
    logic        rstn;       // async reset, active low
    logic [9:0]  wb_adr;     // byte address, index in bits 9:2
    logic [31:0] wb_dat;     // write data, lane 0 only
    logic [3:0]  wb_sel;     // byte enables
    logic        wb_we;      // write strobe
    logic        wb_cyc;     // bus cycle
    logic        wb_stb;     // bus strobe
    logic [31:0] wb_dat_o;   // read data from the block
    logic        wb_ack_o;   // one-cycle answer
    logic [7:0]  evt;        // event lines in pending-register layout
    logic        irq_o;      // level interrupt
    logic [31:0] rdv;        // last value read
    int          error_cnt;  // mismatches seen
    int          cmp_count;  // comparisons made

    ////////////////////////////////////////////////////////////////////////////////////////
    // device under test
    iai_regs u_iai_regs (
        .ref_clk          (ref_clk),
        .rstn             (rstn),
        .wb_adr_i         (wb_adr),
        .wb_dat_i         (wb_dat),
        .wb_sel_i         (wb_sel),
        .wb_we_i          (wb_we),
        .wb_cyc_i         (wb_cyc),
        .wb_stb_i         (wb_stb),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .alarm_evt        (evt[7:2]),
        .loop_closure_evt (evt[1]),
        .ring_trip_evt    (evt[0]),
        .irq_o            (irq_o)
    );

    // clock generator
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run, shared by the tests and the watchdog
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // single comparison point, four-state exact
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one classic cycle; waits for ack with a bound, since latency is not assumed
    task automatic wb_cycle(input logic we, input logic [7:0] idx, input logic [7:0] d,
                            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1, "bus answer missing");
        end
        q = wb_dat_o;   // taken at the ack edge only
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        wb_cycle(1'b0, idx, 8'h00, rdv);
        chk(rdv, {24'h000000, exp}, what);
    endtask

    // one-cycle event pulse on a pending bit position
    task automatic pulse(input int b);
        @(posedge ref_clk);
        evt <= 8'h01 << b;
        @(posedge ref_clk);
        evt <= 8'h00;
        repeat (3) @(posedge ref_clk);
    endtask

    // poll busy; a tick is 1250 cycles so 600 reads of 3 cycles is ample
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb_cycle(1'b0, IDX_ISTAT, 8'h00, rdv);
            n++;
        end while (rdv[BUSY_BIT] !== 1'b0 && n < 600);
        chk(rdv, 32'h0, "busy never cleared");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // watchdog: tests need roughly 5000 cycles, allow 40000
    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] m;
        error_cnt = 0;
        cmp_count = 0;
        rstn = 1'b0;
        wb_adr = 10'h000;
        wb_dat = 32'h00000000;
        wb_sel = 4'hF;
        wb_we = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        evt = 8'h00;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;

        // reset values, including an unmapped index that must read zero
        rd(IDX_EN2, EN2_RST, "en2 reset");
        rd(IDX_EN3, EN3_RST, "en3 reset");
        rd(IDX_DATA_LO, 8'h00, "data low reset");
        rd(IDX_ADDR, ADDR_RST, "address reset");
        rd(IDX_ISTAT, 8'h00, "busy reset");
        rd(8'h40, 8'h00, "unmapped read");
        $display("test reset done");

        // enable registers: full width on two, masked on three
        wr(IDX_EN2, 8'hFF);
        rd(IDX_EN2, 8'hFF, "en2 all ones");
        // a write without lane zero enabled must leave the register alone
        wb_sel <= 4'hE;
        wr(IDX_EN2, 8'h00);
        wb_sel <= 4'hF;
        rd(IDX_EN2, 8'hFF, "lane zero off ignored");
        wr(IDX_EN3, 8'hFF);
        rd(IDX_EN3, 8'h03, "en3 reserved read zero");
        wr(IDX_EN3, 8'hFD);
        rd(IDX_EN3, 8'h01, "en3 spare bit only");
        $display("test enables done");

        // every line event: wrong mask keeps irq low, right mask raises it
        for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            wr(IDX_EN3, 8'h00);
            wr(IDX_EN2, ~m);
            pulse(b);
            chk({31'h0, irq_o}, 32'h0, "masked flag raised irq");
            rd(IDX_STAT2, m, "pending flag");
            wr(IDX_STAT2, ~m);
            rd(IDX_STAT2, m, "write zero kept flag");
            wr(IDX_EN2, m);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, irq_o}, 32'h1, "enabled flag irq");
            wr(IDX_STAT2, m);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, irq_o}, 32'h0, "irq after clear");
            rd(IDX_STAT2, 8'h00, "flag cleared");
        end
        wr(IDX_EN2, 8'h00);
        $display("test line events done");

        // indirect writes, bytes in both orders, boundary location last
        wr(IDX_EN3, 8'h02);
        wr(IDX_DATA_LO, 8'h34);
        wr(IDX_DATA_HI, 8'h12);
        wr(IDX_ADDR, 8'h05);
        rd(IDX_ISTAT, 8'h01, "busy while pending");
        wait_idle();
        rd(IDX_STAT3, 8'h02, "done flag set");
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq_o}, 32'h1, "done irq enabled");
        wr(IDX_STAT3, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq_o}, 32'h0, "done irq cleared");
        rd(IDX_STAT3, 8'h00, "done flag cleared");
        wr(IDX_DATA_HI, 8'hAB);
        wr(IDX_DATA_LO, 8'hCD);
        wr(IDX_ADDR, 8'hFF);
        wait_idle();
        rd(IDX_ADDR, 8'hFF, "address readback");
        $display("test indirect write done");

        // indirect reads: address only, data word loaded one cycle after the tick
        wr(IDX_STAT3, 8'h02);
        wr(IDX_ADDR, 8'h05);
        wait_idle();
        rd(IDX_DATA_LO, 8'h34, "read low byte");
        rd(IDX_DATA_HI, 8'h12, "read high byte");
        rd(IDX_STAT3, 8'h02, "done after read");
        wr(IDX_ADDR, 8'hFF);
        wait_idle();
        rd(IDX_DATA_LO, 8'hCD, "read low byte top");
        rd(IDX_DATA_HI, 8'hAB, "read high byte top");
        $display("test indirect read done");

        end_sim();
    end
endmodule // tb_top
